// ### rtl/cox_pkg.sv
// Constants shared by the opcode execution subset
package cox_pkg;
	// Summary of operation
	// - Loop decrement, branch if nonzero, flags kept
	// - Divide H:A by X, quotient A, remainder H
	// - Multiply A by X into X:A, clear H, C
	// - Push A/H/X at SP, then decrement SP
	// - Increment SP, then pull A/H/X from stack
	// - Return pulls PC high then low, four cycles
	// - Halt clears interrupt mask, stops oscillator
	// - Test sets N and Z, writes nothing
	// - Copy byte; index forms post-increment H:X
	// - Xor operand into A, V cleared, N Z
	// - Or operand into A, V cleared, N Z
	// - Plus one in place, V N Z, carry kept
	// - Minus one in place, V N Z, carry kept
	// - Negate operand, V N Z C updated
	// - Shift left, bit 7 to carry, zero in
	// - Rotate left through carry, V N Z from result
	// - Rotate right through carry, V N Z from result
	// - Prefix byte selects stack-offset opcode forms
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_OPCODE = 8'h00;
	localparam logic [7:0] REG_OPERAND = 8'h04;
	localparam logic [7:0] REG_ACC = 8'h08;
	localparam logic [7:0] REG_INDEX = 8'h0c;
	localparam logic [7:0] REG_SP = 8'h10;
	localparam logic [7:0] REG_PC = 8'h14;
	localparam logic [7:0] REG_FLAGS = 8'h18;
	localparam logic [7:0] REG_CTRL = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_MOUT = 8'h24;
	localparam logic [7:0] REG_CYC = 8'h28;
	localparam logic [1:0] STK_WIN_SEL = 2'h1;
	localparam int OPC_PRE_BIT = 8;
	localparam int OPR_REL_LSB = 8;
	localparam int IDX_H_LSB = 8;
	localparam int CTL_START_BIT = 0;
	localparam int CTL_WAKE_BIT = 1;
	localparam int CTL_CLR_ILL_BIT = 2;
	localparam int V_BIT = 7;
	localparam int H_BIT = 4;
	localparam int I_BIT = 3;
	localparam int N_BIT = 2;
	localparam int Z_BIT = 1;
	localparam int C_BIT = 0;
	localparam logic [7:0] CCR_RST = 8'h68;
	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [7:0] OP_PREFIX = 8'h9e;
	localparam logic [7:0] OP_MUL = 8'h42;
	localparam logic [7:0] OP_DIV = 8'h52;
	localparam logic [7:0] OP_PUSH_A = 8'h87;
	localparam logic [7:0] OP_PUSH_H = 8'h8b;
	localparam logic [7:0] OP_PUSH_X = 8'h89;
	localparam logic [7:0] OP_POP_A = 8'h86;
	localparam logic [7:0] OP_POP_H = 8'h8a;
	localparam logic [7:0] OP_POP_X = 8'h88;
	localparam logic [7:0] OP_RTS = 8'h81;
	localparam logic [7:0] OP_STOP = 8'h8e;
	localparam logic [7:0] OP_MOV_DD = 8'h4e;
	localparam logic [7:0] OP_MOV_IMD = 8'h6e;
	localparam logic [3:0] LO_NEG = 4'h0;
	localparam logic [3:0] LO_ROR = 4'h6;
	localparam logic [3:0] LO_LSL = 4'h8;
	localparam logic [3:0] LO_ROL = 4'h9;
	localparam logic [3:0] LO_DEC = 4'ha;
	localparam logic [3:0] LO_LOOP_DECREMENT_BRANCH_OP = 4'hb;
	localparam logic [3:0] LO_INC = 4'hc;
	localparam logic [3:0] LO_TST = 4'hd;
	localparam logic [3:0] LO_MOV = 4'he;
	localparam logic [3:0] LO_EOR = 4'h8;
	localparam logic [3:0] LO_ORA = 4'ha;
	localparam logic [3:0] HI_DIR_RMW = 4'h3;
	localparam logic [3:0] HI_INH_A = 4'h4;
	localparam logic [3:0] HI_INH_X = 4'h5;
	localparam logic [3:0] HI_IX1_RMW = 4'h6;
	localparam logic [3:0] HI_IX_RMW = 4'h7;
	localparam logic [3:0] HI_IMM = 4'ha;
	localparam logic [3:0] HI_DIR = 4'hb;
	localparam logic [3:0] HI_EXT = 4'hc;
	localparam logic [3:0] HI_IX2 = 4'hd;
	localparam logic [3:0] HI_IX1 = 4'he;
	localparam logic [3:0] HI_SP2 = 4'hd;
	localparam logic [3:0] HI_SP1 = 4'he;
	localparam logic [2:0] CYC_INH = 3'h1;
	localparam logic [2:0] CYC_DIR_RMW = 3'h4;
	localparam logic [2:0] CYC_IX1_RMW = 3'h4;
	localparam logic [2:0] CYC_IX_RMW = 3'h3;
	localparam logic [2:0] CYC_SP1_RMW = 3'h5;
	localparam logic [2:0] CYC_IMM = 3'h2;
	localparam logic [2:0] CYC_DIR = 3'h3;
	localparam logic [2:0] CYC_EXT = 3'h4;
	localparam logic [2:0] CYC_IX2 = 3'h4;
	localparam logic [2:0] CYC_IX1 = 3'h3;
	localparam logic [2:0] CYC_IX = 3'h2;
	localparam logic [2:0] CYC_SP1 = 3'h4;
	localparam logic [2:0] CYC_SP2 = 3'h5;
	localparam logic [2:0] CYC_MUL = 3'h5;
	localparam logic [2:0] CYC_DIV = 3'h7;
	localparam logic [2:0] CYC_STACK = 3'h2;
	localparam logic [2:0] CYC_RTS = 3'h4;
	localparam logic [2:0] CYC_MOV_DD = 3'h5;
	localparam logic [2:0] CYC_MOV = 3'h4;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_TWO = 3'h2;
	localparam logic [2:0] LEN_THREE = 3'h3;
	localparam logic [2:0] LEN_FOUR = 3'h4;
endpackage : cox_pkg

// ### rtl/cox_stk_if.sv
`timescale 1ns/10ps
// Signals between the executor and its stack byte store
interface cox_stk_if #(
	parameter int AW = 4
);
	logic we;
	logic [AW-1:0] waddr;
	logic [7:0] wdata;
	logic [AW-1:0] ra1;
	logic [AW-1:0] ra2;
	logic [AW-1:0] raw;
	logic [7:0] rd1;
	logic [7:0] rd2;
	logic [7:0] rdw;
	modport ctl (output we, waddr, wdata, ra1, ra2, raw, input rd1, rd2, rdw);
	modport mem (input we, waddr, wdata, ra1, ra2, raw, output rd1, rd2, rdw);
endinterface : cox_stk_if

// ### rtl/cox_stack.sv
`timescale 1ns/10ps
// Stack byte store with one write port and three read ports
module cox_stack #(
	parameter int AW = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	cox_stk_if.mem stk
);
	logic [7:0] mem_r [2**AW];

	for (genvar i = 0; i < 2**AW; i++) begin : g_ent
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem_r[i] <= 8'h00;
			end else if (stk.we && stk.waddr == AW'(i)) begin
				mem_r[i] <= stk.wdata;
			end
		end
	end

	assign stk.rd1 = mem_r[stk.ra1];
	assign stk.rd2 = mem_r[stk.ra2];
	assign stk.rdw = mem_r[stk.raw];
endmodule : cox_stack

// ### rtl/cox_exec.sv
`timescale 1ns/10ps
// Opcode decode and execute unit with APB register access
module cox_exec #(
	parameter int STACK_AW = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cox_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic osc_stop,
	output logic irq_pin_en,
	output logic illegal_opcode
);
	import cox_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_HALT = 3'b100
	} cox_state_t;

	cox_state_t state_r;
	logic [7:0] op_r;
	logic pre_r;
	logic [7:0] m_r;
	logic [7:0] rel_r;
	logic [7:0] acc_r;
	logic [7:0] h_r;
	logic [7:0] x_r;
	logic [15:0] sp_r;
	logic [15:0] pc_r;
	logic [7:0] ccr_r;
	logic [7:0] mout_r;
	logic mwr_r;
	logic ill_r;
	logic [2:0] cnt_r;
	logic [2:0] lastcyc_r;
	logic [31:0] prdata_r;
	logic slverr_r;
	logic illp_r;

	cox_stk_if #(.AW(STACK_AW)) stk_bus ();

	cox_stack #(.AW(STACK_AW)) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.stk(stk_bus.mem)
	);

	// Decode
	logic [3:0] hi;
	logic [3:0] lo;
	logic col_rmw;
	logic lo_rmw;
	logic is_rmw;
	logic is_log;
	logic is_mov;
	logic is_sgl;
	logic illegal_w;
	logic inh_a;
	logic inh_x;
	logic [7:0] src;
	assign hi = op_r[7:4];
	assign lo = op_r[3:0];
	assign col_rmw = pre_r ? (hi == HI_IX1_RMW) : (hi >= HI_DIR_RMW && hi <= HI_IX_RMW);
	assign lo_rmw = lo == LO_NEG || lo == LO_ROR || lo == LO_LSL || lo == LO_ROL || lo == LO_DEC
		|| lo == LO_LOOP_DECREMENT_BRANCH_OP || lo == LO_INC || lo == LO_TST;
	assign is_rmw = col_rmw && lo_rmw;
	assign is_log = (pre_r ? (hi == HI_SP2 || hi == HI_SP1) : (hi >= HI_IMM)) && (lo == LO_EOR || lo == LO_ORA);
	assign is_mov = !pre_r && lo == LO_MOV && hi >= HI_INH_A && hi <= HI_IX_RMW;
	assign is_sgl = !pre_r && (op_r == OP_MUL || op_r == OP_DIV || op_r == OP_PUSH_A || op_r == OP_PUSH_H
		|| op_r == OP_PUSH_X || op_r == OP_POP_A || op_r == OP_POP_H || op_r == OP_POP_X
		|| op_r == OP_RTS || op_r == OP_STOP);
	assign illegal_w = !(is_rmw || is_log || is_mov || is_sgl);
	assign inh_a = !pre_r && hi == HI_INH_A;
	assign inh_x = !pre_r && hi == HI_INH_X;
	assign src = inh_a ? acc_r : (inh_x ? x_r : m_r);

	// Length and cycle count
	logic [2:0] len_w;
	logic [2:0] cyc_w;
	logic [2:0] base_w;
	logic [2:0] blen_w;
	always_comb begin
		base_w = CYC_INH;
		blen_w = LEN_ONE;
		if (pre_r) begin
			base_w = CYC_SP1_RMW;
			blen_w = LEN_THREE;
		end else if (hi == HI_DIR_RMW) begin
			base_w = CYC_DIR_RMW;
			blen_w = LEN_TWO;
		end else if (hi == HI_IX1_RMW) begin
			base_w = CYC_IX1_RMW;
			blen_w = LEN_TWO;
		end else if (hi == HI_IX_RMW) begin
			base_w = CYC_IX_RMW;
		end
		len_w = LEN_ONE;
		cyc_w = CYC_INH;
		if (is_rmw) begin
			len_w = blen_w;
			cyc_w = base_w;
			if (lo == LO_TST && !(inh_a || inh_x)) begin
				cyc_w = base_w - 3'h1;
			end else if (lo == LO_LOOP_DECREMENT_BRANCH_OP) begin
				len_w = blen_w + 3'h1;
				cyc_w = (inh_a || inh_x) ? base_w + 3'h2 : base_w + 3'h1;
			end
		end else if (is_log) begin
			if (pre_r) begin
				cyc_w = (hi == HI_SP2) ? CYC_SP2 : CYC_SP1;
				len_w = (hi == HI_SP2) ? LEN_FOUR : LEN_THREE;
			end else begin
				case (hi)
					HI_IMM: begin cyc_w = CYC_IMM; len_w = LEN_TWO; end
					HI_DIR: begin cyc_w = CYC_DIR; len_w = LEN_TWO; end
					HI_EXT: begin cyc_w = CYC_EXT; len_w = LEN_THREE; end
					HI_IX2: begin cyc_w = CYC_IX2; len_w = LEN_THREE; end
					HI_IX1: begin cyc_w = CYC_IX1; len_w = LEN_TWO; end
					default: begin cyc_w = CYC_IX; len_w = LEN_ONE; end
				endcase
			end
		end else if (is_mov) begin
			cyc_w = (op_r == OP_MOV_DD) ? CYC_MOV_DD : CYC_MOV;
			len_w = (op_r == OP_MOV_DD || op_r == OP_MOV_IMD) ? LEN_THREE : LEN_TWO;
		end else if (op_r == OP_MUL) begin
			cyc_w = CYC_MUL;
		end else if (op_r == OP_DIV) begin
			cyc_w = CYC_DIV;
		end else if (op_r == OP_RTS) begin
			cyc_w = CYC_RTS;
		end else if (op_r != OP_STOP) begin
			cyc_w = CYC_STACK;
		end
	end

	// Datapath
	logic [7:0] acc_nxt;
	logic [7:0] h_nxt;
	logic [7:0] x_nxt;
	logic [15:0] sp_nxt;
	logic [15:0] pc_nxt;
	logic [7:0] ccr_nxt;
	logic [7:0] mout_nxt;
	logic mwr_nxt;
	logic stk_wr_w;
	logic [7:0] stk_wd_w;
	logic halt_w;
	logic [7:0] res;
	logic [15:0] prod;
	logic [15:0] quot;
	logic [7:0] rem;
	logic [15:0] hx_inc;
	assign prod = acc_r * x_r;
	assign quot = {h_r, acc_r} / {8'h00, (x_r == 8'h00) ? 8'h01 : x_r};
	assign rem = 8'({h_r, acc_r} % {8'h00, (x_r == 8'h00) ? 8'h01 : x_r});
	assign hx_inc = {h_r, x_r} + 16'h0001;
	always_comb begin
		acc_nxt = acc_r;
		h_nxt = h_r;
		x_nxt = x_r;
		sp_nxt = sp_r;
		pc_nxt = pc_r + {13'h0000, len_w};
		ccr_nxt = ccr_r;
		mout_nxt = mout_r;
		mwr_nxt = 1'b0;
		stk_wr_w = 1'b0;
		stk_wd_w = acc_r;
		halt_w = 1'b0;
		res = src;
		if (is_rmw) begin
			case (lo)
				LO_NEG: begin
					res = 8'h00 - src;
					ccr_nxt[C_BIT] = res != 8'h00;
					ccr_nxt[V_BIT] = res == 8'h80;
				end
				LO_ROR: begin
					res = {ccr_r[C_BIT], src[7:1]};
					ccr_nxt[C_BIT] = src[0];
					ccr_nxt[V_BIT] = res[7] ^ src[0];
				end
				LO_LSL: begin
					res = {src[6:0], 1'b0};
					ccr_nxt[C_BIT] = src[7];
					ccr_nxt[V_BIT] = res[7] ^ src[7];
				end
				LO_ROL: begin
					res = {src[6:0], ccr_r[C_BIT]};
					ccr_nxt[C_BIT] = src[7];
					ccr_nxt[V_BIT] = res[7] ^ src[7];
				end
				LO_DEC: begin
					res = src - 8'h01;
					ccr_nxt[V_BIT] = res == 8'h7f;
				end
				LO_INC: begin
					res = src + 8'h01;
					ccr_nxt[V_BIT] = res == 8'h80;
				end
				LO_LOOP_DECREMENT_BRANCH_OP: begin
					res = src - 8'h01;
					if (res != 8'h00) begin
						pc_nxt = pc_r + {13'h0000, len_w} + {{8{rel_r[7]}}, rel_r};
					end
				end
				default: begin
					res = src;
				end
			endcase
			if (lo != LO_LOOP_DECREMENT_BRANCH_OP) begin
				ccr_nxt[N_BIT] = res[7];
				ccr_nxt[Z_BIT] = res == 8'h00;
			end
			if (lo != LO_TST) begin
				if (inh_a) begin
					acc_nxt = res;
				end else if (inh_x) begin
					x_nxt = res;
				end else begin
					mout_nxt = res;
					mwr_nxt = 1'b1;
				end
			end
		end else if (is_log) begin
			res = (lo == LO_EOR) ? (acc_r ^ m_r) : (acc_r | m_r);
			acc_nxt = res;
			ccr_nxt[V_BIT] = 1'b0;
			ccr_nxt[N_BIT] = res[7];
			ccr_nxt[Z_BIT] = res == 8'h00;
		end else if (is_mov) begin
			mout_nxt = m_r;
			mwr_nxt = 1'b1;
			ccr_nxt[V_BIT] = 1'b0;
			ccr_nxt[N_BIT] = m_r[7];
			ccr_nxt[Z_BIT] = m_r == 8'h00;
			if (op_r != OP_MOV_DD && op_r != OP_MOV_IMD) begin
				h_nxt = hx_inc[15:8];
				x_nxt = hx_inc[7:0];
			end
		end else begin
			case (op_r)
				OP_MUL: begin
					x_nxt = prod[15:8];
					acc_nxt = prod[7:0];
					ccr_nxt[H_BIT] = 1'b0;
					ccr_nxt[C_BIT] = 1'b0;
				end
				OP_DIV: begin
					if (x_r == 8'h00 || h_r >= x_r) begin
						ccr_nxt[C_BIT] = 1'b1;
					end else begin
						acc_nxt = quot[7:0];
						h_nxt = rem;
						ccr_nxt[C_BIT] = 1'b0;
						ccr_nxt[Z_BIT] = quot[7:0] == 8'h00;
					end
				end
				OP_PUSH_A, OP_PUSH_H, OP_PUSH_X: begin
					stk_wr_w = 1'b1;
					stk_wd_w = (op_r == OP_PUSH_A) ? acc_r : ((op_r == OP_PUSH_H) ? h_r : x_r);
					sp_nxt = sp_r - 16'h0001;
				end
				OP_POP_A: begin
					acc_nxt = stk_bus.rd1;
					sp_nxt = sp_r + 16'h0001;
				end
				OP_POP_H: begin
					h_nxt = stk_bus.rd1;
					sp_nxt = sp_r + 16'h0001;
				end
				OP_POP_X: begin
					x_nxt = stk_bus.rd1;
					sp_nxt = sp_r + 16'h0001;
				end
				OP_RTS: begin
					pc_nxt = {stk_bus.rd1, stk_bus.rd2};
					sp_nxt = sp_r + 16'h0002;
				end
				OP_STOP: begin
					ccr_nxt[I_BIT] = 1'b0;
					halt_w = 1'b1;
				end
				default: begin
					halt_w = 1'b0;
				end
			endcase
		end
	end

	// Sequencing and APB decode
	logic idle;
	logic commit;
	logic aligned;
	logic stk_hit;
	logic mapped;
	logic wr_en;
	logic we_stk;
	logic ctl_wr;
	logic start;
	logic ill_set;
	logic ill_clr;
	logic [31:0] rd_mux;
	assign idle = state_r == ST_IDLE;
	assign commit = state_r == ST_EXEC && cnt_r == 3'h0;
	assign aligned = paddr[1:0] == 2'h0;
	assign stk_hit = aligned && paddr[7:6] == STK_WIN_SEL;
	assign mapped = stk_hit || (aligned && paddr <= REG_CYC);
	assign wr_en = psel && penable && pwrite && mapped;
	assign we_stk = wr_en && idle && stk_hit;
	assign ctl_wr = wr_en && paddr == REG_CTRL;
	assign start = ctl_wr && pwdata[CTL_START_BIT] && idle;
	assign ill_set = start && illegal_w;
	assign ill_clr = ctl_wr && pwdata[CTL_CLR_ILL_BIT];
	assign stk_bus.we = we_stk || (commit && stk_wr_w);
	assign stk_bus.waddr = we_stk ? paddr[2 +: STACK_AW] : sp_r[STACK_AW-1:0];
	assign stk_bus.wdata = we_stk ? pwdata[7:0] : stk_wd_w;
	assign stk_bus.ra1 = STACK_AW'(sp_r + 16'h0001);
	assign stk_bus.ra2 = STACK_AW'(sp_r + 16'h0002);
	assign stk_bus.raw = paddr[2 +: STACK_AW];
	assign rd_mux = stk_hit ? {24'h000000, stk_bus.rdw}
		: (paddr == REG_OPCODE) ? {23'h000000, pre_r, op_r}
		: (paddr == REG_OPERAND) ? {16'h0000, rel_r, m_r}
		: (paddr == REG_ACC) ? {24'h000000, acc_r}
		: (paddr == REG_INDEX) ? {16'h0000, h_r, x_r}
		: (paddr == REG_SP) ? {16'h0000, sp_r}
		: (paddr == REG_PC) ? {16'h0000, pc_r}
		: (paddr == REG_FLAGS) ? {24'h000000, ccr_r}
		: (paddr == REG_STATUS) ? {28'h0000000, mwr_r, state_r == ST_HALT, ill_r, state_r == ST_EXEC}
		: (paddr == REG_MOUT) ? {24'h000000, mout_r}
		: (paddr == REG_CYC) ? {29'h00000000, lastcyc_r}
		: 32'h00000000;
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = slverr_r;
	assign osc_stop = state_r == ST_HALT;
	assign irq_pin_en = !ccr_r[I_BIT];
	assign illegal_opcode = illp_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			slverr_r <= 1'b0;
		end else if (psel && !penable) begin
			prdata_r <= pwrite ? 32'h00000000 : rd_mux;
			slverr_r <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			lastcyc_r <= 3'h0;
			ill_r <= 1'b0;
			illp_r <= 1'b0;
			mwr_r <= 1'b0;
		end else begin
			ill_r <= ill_set || (ill_r && !ill_clr);
			illp_r <= ill_set;
			case (state_r)
				ST_IDLE: begin
					if (start && !illegal_w) begin
						state_r <= ST_EXEC;
						cnt_r <= cyc_w - 3'h1;
						lastcyc_r <= cyc_w;
						mwr_r <= 1'b0;
					end
				end
				ST_EXEC: begin
					cnt_r <= cnt_r - 3'h1;
					if (commit) begin
						mwr_r <= mwr_nxt;
						state_r <= halt_w ? ST_HALT : ST_IDLE;
					end
				end
				ST_HALT: begin
					if (ctl_wr && pwdata[CTL_WAKE_BIT]) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= 8'h00;
			pre_r <= 1'b0;
			m_r <= 8'h00;
			rel_r <= 8'h00;
			acc_r <= 8'h00;
			h_r <= 8'h00;
			x_r <= 8'h00;
			sp_r <= SP_RST;
			pc_r <= 16'h0000;
			ccr_r <= CCR_RST;
			mout_r <= 8'h00;
		end else if (commit) begin
			acc_r <= acc_nxt;
			h_r <= h_nxt;
			x_r <= x_nxt;
			sp_r <= sp_nxt;
			pc_r <= pc_nxt;
			ccr_r <= ccr_nxt;
			mout_r <= mout_nxt;
		end else if (wr_en && idle) begin
			case (paddr)
				REG_OPCODE: begin
					op_r <= pwdata[7:0];
					pre_r <= pwdata[OPC_PRE_BIT];
				end
				REG_OPERAND: begin
					m_r <= pwdata[7:0];
					rel_r <= pwdata[OPR_REL_LSB +: 8];
				end
				REG_ACC: acc_r <= pwdata[7:0];
				REG_INDEX: begin
					h_r <= pwdata[IDX_H_LSB +: 8];
					x_r <= pwdata[7:0];
				end
				REG_SP: sp_r <= pwdata[15:0];
				REG_PC: pc_r <= pwdata[15:0];
				REG_FLAGS: ccr_r <= pwdata[7:0];
				default: mout_r <= mout_r;
			endcase
		end
	end
endmodule : cox_exec

// ### test/cox_exec_assertions.sv
`timescale 1ns/10ps
// Concurrent checks on the execution unit ports
module cox_exec_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cox_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_stop,
	input wire logic irq_pin_en,
	input wire logic illegal_opcode
);
	import cox_pkg::*;
	wire logic acc_wr = psel && penable && pwrite;
	wire logic start_wr = acc_wr && paddr == REG_CTRL && pwdata[CTL_START_BIT];
	wire logic wake_wr = acc_wr && paddr == REG_CTRL && pwdata[CTL_WAKE_BIT];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ill_pulse; illegal_opcode |=> !illegal_opcode; endproperty
	a_ill_pulse: assert property (p_ill_pulse) else $error("illegal pulse too long");
	property p_ill_cause; illegal_opcode |-> $past(start_wr); endproperty
	a_ill_cause: assert property (p_ill_cause) else $error("illegal pulse without start");
	property p_stop_irq; $rose(osc_stop) |-> irq_pin_en; endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("halt kept mask set");
	property p_stop_lat; $rose(osc_stop) |-> $past(start_wr, 2); endproperty
	a_stop_lat: assert property (p_stop_lat) else $error("halt not one cycle");
	property p_stop_hold; osc_stop && !wake_wr |=> osc_stop; endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("halt left without wake");
	property p_wake; osc_stop && wake_wr |=> !osc_stop; endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");
	property p_irq_src;
		$changed(irq_pin_en) |-> $past(acc_wr && paddr == REG_FLAGS) || $rose(osc_stop);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("mask changed without cause");
	property p_slverr; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && pready; endproperty
	a_slverr: assert property (p_slverr) else $error("unaligned access not refused");
endmodule : cox_exec_assertions

bind cox_exec cox_exec_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.osc_stop(osc_stop), .irq_pin_en(irq_pin_en), .illegal_opcode(illegal_opcode));

// ### test/cox_apb_master.sv
`timescale 1ns/10ps
// Bus master model for register cycles
module cox_apb_master (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [cox_pkg::APB_AW-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import cox_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : cox_apb_master

// ### test/tb_cpu_opcode_exec_subset.sv
`timescale 1ns/10ps
// Self-checking bench for the opcode execution unit
module tb_cpu_opcode_exec_subset;
	import cox_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_stop, irq_pin_en, illegal_opcode, e;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [31:0] seed = 32'ha6d5bf3a;
	logic [7:0] a, x, h, m, fl, fe, r;
	logic [15:0] w;
	int n_errors = 0;
	int checks = 0;
	int n_ill = 0;
	logic [3:0] los [7] = '{LO_NEG, LO_ROR, LO_LSL, LO_ROL, LO_DEC, LO_INC, LO_TST};
	logic [7:0] pu [3] = '{OP_PUSH_A, OP_PUSH_H, OP_PUSH_X};
	logic [7:0] po [3] = '{OP_POP_X, OP_POP_A, OP_POP_H};
	logic [7:0] mv [3] = '{OP_MOV_DD, OP_MOV_IMD, 8'h7e};
	logic [2:0] mc [3] = '{CYC_MOV_DD, CYC_MOV, CYC_MOV};
	cox_exec #(.STACK_AW(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_stop(osc_stop), .irq_pin_en(irq_pin_en), .illegal_opcode(illegal_opcode));
	cox_apb_master m_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) if (illegal_opcode === 1'b1) n_ill <= n_ill + 1;
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] setnz(logic [7:0] f, logic [7:0] v);
		f[N_BIT] = v[7];
		f[Z_BIT] = (v == 8'h00);
		return f;
	endfunction : setnz
	function automatic logic [15:0] exp_rmw(logic [3:0] lo, logic [7:0] v, logic [7:0] f);
		logic [7:0] s;
		logic c;
		c = f[C_BIT];
		case (lo)
			LO_NEG: begin s = 8'h00 - v; c = (s != 8'h00); end
			LO_ROR: begin s = {c, v[7:1]}; c = v[0]; end
			LO_LSL: begin s = {v[6:0], 1'b0}; c = v[7]; end
			LO_ROL: begin s = {v[6:0], c}; c = v[7]; end
			LO_DEC: s = v - 8'h01;
			LO_INC: s = v + 8'h01;
			default: s = v;
		endcase
		f = setnz(f, s);
		if (lo != LO_TST) f[C_BIT] = c;
		if (lo == LO_NEG || lo == LO_INC) f[V_BIT] = (s == 8'h80);
		else if (lo == LO_DEC) f[V_BIT] = (s == 8'h7f);
		else if (lo != LO_TST) f[V_BIT] = s[7] ^ c;
		return {f, s};
	endfunction : exp_rmw
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		m_u.xfer(1'b1, ad, d, q, e);
	endtask : wr
	task automatic rchk(input logic [7:0] ad, input logic [31:0] expv);
		m_u.xfer(1'b0, ad, 32'h0, q, e);
		chk(q, expv);
	endtask : rchk
	task automatic run(input logic [8:0] op, input logic [7:0] ac, input logic [15:0] ix, input logic [7:0] f,
		input logic [15:0] od);
		wr(REG_OPCODE, {23'h0, op});
		wr(REG_ACC, {24'h0, ac});
		wr(REG_INDEX, {16'h0, ix});
		wr(REG_FLAGS, {24'h0, f});
		wr(REG_OPERAND, {16'h0, od});
		wr(REG_CTRL, 32'h1);
		for (int k = 0; k < 20; k++) begin
			m_u.xfer(1'b0, REG_STATUS, 32'h0, q, e);
			if (q[0] !== 1'b1) break;
		end
	endtask : run
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		final_report();
	end
	initial begin
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rchk(REG_FLAGS, {24'h0, CCR_RST});
		rchk(REG_SP, {16'h0, SP_RST});
		for (int i = 0; i < 35; i++) begin
			a = (i < 7) ? 8'h80 : (i < 14) ? 8'h7f : (i < 21) ? 8'h00 : rnd();
			fl = rnd();
			w = exp_rmw(los[i % 7], a, fl);
			run({1'b0, i[0] ? HI_INH_X : HI_INH_A, los[i % 7]}, a, {8'h00, a}, fl, 16'h0);
			rchk(REG_ACC, {24'h0, i[0] ? a : w[7:0]});
			rchk(REG_INDEX, {24'h0, i[0] ? w[7:0] : a});
			rchk(REG_FLAGS, {24'h0, w[15:8]});
			rchk(REG_CYC, {29'h0, CYC_INH});
		end
		for (int i = 0; i < 8; i++) begin
			a = rnd();
			m = rnd();
			fl = rnd();
			x = (i == 0) ? 8'h00 : rnd() | 8'h01;
			h = (i == 0) ? rnd() : rnd() % x;
			r = (i == 0) ? 8'h00 : a - 8'h01;
			wr(REG_PC, 32'h1000);
			run({1'b0, HI_INH_A, LO_LOOP_DECREMENT_BRANCH_OP}, r + 8'h01, 16'h0, fl, {m, 8'h00});
			w = 16'h1002 + ((r != 8'h00) ? {{8{m[7]}}, m} : 16'h0);
			rchk(REG_PC, {16'h0, w});
			rchk(REG_FLAGS, {24'h0, fl});
			rchk(REG_CYC, 32'h3);
			run({1'b0, HI_IMM, LO_EOR}, a, 16'h0, fl, {8'h00, m});
			rchk(REG_ACC, {24'h0, a ^ m});
			fe = setnz(fl, a ^ m) & ~8'h80;
			rchk(REG_FLAGS, {24'h0, fe});
			run({1'b0, HI_IMM, LO_ORA}, a, 16'h0, fl, {8'h00, m});
			fe = setnz(fl, a | m) & ~8'h80;
			rchk(REG_FLAGS, {24'h0, fe});
			rchk(REG_CYC, {29'h0, CYC_IMM});
			w = a * x;
			run({1'b0, OP_MUL}, a, {h, x}, fl, 16'h0);
			rchk(REG_INDEX, {16'h0, h, w[15:8]});
			rchk(REG_ACC, {24'h0, w[7:0]});
			rchk(REG_FLAGS, {24'h0, fl & ~8'h11});
			rchk(REG_CYC, {29'h0, CYC_MUL});
			run({1'b0, OP_DIV}, a, {h, x}, fl, 16'h0);
			fe = fl;
			fe[C_BIT] = (x == 8'h00);
			if (x != 8'h00) begin
				r = 8'({h, a} % x);
				a = 8'({h, a} / x);
				h = r;
				fe[Z_BIT] = (a == 8'h00);
			end
			rchk(REG_ACC, {24'h0, a});
			rchk(REG_INDEX, {16'h0, h, x});
			rchk(REG_FLAGS, {24'h0, fe});
			rchk(REG_CYC, {29'h0, CYC_DIV});
		end
		for (int i = 0; i < 3; i++) begin
			a = rnd();
			run({1'b0, pu[i]}, a, {a, a}, CCR_RST, 16'h0);
			rchk(REG_SP, 32'hfe);
			rchk(8'h7c, {24'h0, a});
			run({1'b0, po[i]}, 8'h00, 16'h0, CCR_RST, 16'h0);
			rchk(REG_SP, 32'hff);
			rchk(REG_ACC, {24'h0, (i == 1) ? a : 8'h00});
			rchk(REG_INDEX, {16'h0, (i == 2) ? a : 8'h00, (i == 0) ? a : 8'h00});
			rchk(REG_FLAGS, {24'h0, CCR_RST});
			m = rnd();
			run({1'b0, mv[i]}, 8'h00, 16'h12ff, CCR_RST, {8'h00, m});
			rchk(REG_MOUT, {24'h0, m});
			rchk(REG_CYC, {29'h0, mc[i]});
			rchk(REG_INDEX, (i == 2) ? 32'h1300 : 32'h12ff);
		end
		run({1'b0, OP_PUSH_A}, 8'h34, 16'h0, CCR_RST, 16'h0);
		run({1'b0, OP_PUSH_A}, 8'h12, 16'h0, CCR_RST, 16'h0);
		run({1'b0, OP_RTS}, 8'h00, 16'h0, CCR_RST, 16'h0);
		rchk(REG_PC, 32'h1234);
		rchk(REG_SP, 32'hff);
		rchk(REG_CYC, {29'h0, CYC_RTS});
		run({1'b1, HI_IX1_RMW, LO_INC}, 8'h00, 16'h0, CCR_RST, 16'h7f);
		rchk(REG_MOUT, 32'h80);
		rchk(REG_CYC, {29'h0, CYC_SP1_RMW});
		rchk(REG_STATUS, 32'h8);
		run({1'b1, HI_IX1_RMW, LO_TST}, 8'h00, 16'h0, 8'h60, 16'h80);
		rchk(REG_FLAGS, 32'h64);
		rchk(REG_CYC, 32'h4);
		m_u.xfer(1'b0, 8'h30, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		m_u.xfer(1'b0, 8'h31, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		for (int i = 0; i < 2; i++) begin
			run((i == 0) ? 9'h09d : 9'h16e, 8'h00, 16'h0, CCR_RST, 16'h0);
			m_u.xfer(1'b0, REG_STATUS, 32'h0, q, e);
			chk(q & 32'h7, 32'h2);
			chk(n_ill, i + 1);
			wr(REG_CTRL, 32'h4);
		end
		run({1'b0, OP_STOP}, 8'h00, 16'h0, CCR_RST, 16'h0);
		chk({osc_stop, irq_pin_en}, 2'h3);
		rchk(REG_FLAGS, {24'h0, CCR_RST & ~8'h08});
		wr(REG_CTRL, 32'h2);
		@(negedge pclk);
		chk({osc_stop, irq_pin_en}, 2'h1);
		final_report();
	end
endmodule : tb_cpu_opcode_exec_subset
